// ---- hdl/tsc_cfg.svh ----
// Offsets, field positions, reset values and counts of the time-sync control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TSC_CFG_SVH
`define TSC_CFG_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TSC_PAGE_TIME_SYNC 3'h4
`define TSC_ADDR_CONTROL   5'h14
`define TSC_ADDR_TIME_DATA 5'h15
`define TSC_CONTROL_RESET  16'h0000

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define TSC_SEL_MSB        12
`define TSC_SEL_LSB        10
`define TSC_BIT_TRIG_OFF   9
`define TSC_BIT_TRIG_ON    8
`define TSC_BIT_TRIGGER_READBACK_CMD  7
`define TSC_BIT_TRIGGER_PROGRAM_CMD  6
`define TSC_BIT_CLK_SAMPLE 5
`define TSC_BIT_CLK_SET    4
`define TSC_BIT_CLK_ADJUST 3
`define TSC_BIT_RUN_ON     2
`define TSC_BIT_RUN_OFF    1
`define TSC_BIT_LOGIC_RST  0

// ----------------------------------------------------------------------------
// Time data transfer
// ----------------------------------------------------------------------------
`define TSC_WORD_W         16
`define TSC_CLOCK_WORDS    4
`define TSC_TIME_W         64

`endif

// ---- hdl/tsc_pkg.sv ----
// Types shared by the time-sync control block and its surroundings.
// Assumes the constants header is on the include path.
`include "tsc_cfg.svh"

package tsc_pkg;

  // --------------------------------------------------------------------------
  // Management register access
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [4:0]               addr;
    logic [`TSC_WORD_W-1:0]   wdata;
  } tsc_reg_req_t;

  // --------------------------------------------------------------------------
  // Meaning of the time data port
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    TSC_TDR_CLOCK,
    TSC_TDR_TRIG_RD,
    TSC_TDR_TRIG_LD
  } tsc_tdr_mode_t;

  // --------------------------------------------------------------------------
  // Commands towards the time-sync clock
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic                     logic_reset;
    logic                     run;
    logic                     sample;
    logic                     set;
    logic                     adjust;
    logic [`TSC_TIME_W-1:0]   time_data;
  } tsc_clk_ctl_t;

  // --------------------------------------------------------------------------
  // Commands towards the trigger units
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]               sel;
    logic                     enable;
    logic                     disable_unit;
    logic                     field_wr;
    logic [3:0]               field_idx;
    logic [`TSC_WORD_W-1:0]   field_data;
  } tsc_trig_ctl_t;

endpackage

// ---- hdl/tsc_time_sync_control.sv ----
// Time-sync control register with its time data port sequencing.
// Assumes register accesses come from management logic on clk_in, one cycle long.
`timescale 1ns/1ps
`include "tsc_cfg.svh"

module tsc_time_sync_control
  import tsc_pkg::*;
#(
  parameter int TRIG_UNITS  = 8,
  parameter int TRIG_FIELDS = 6
)
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // Management register access
  input  wire tsc_reg_req_t           reg_req_in,
  input  wire logic [2:0]             page_sel_in,
  output logic [`TSC_WORD_W-1:0]      reg_rdata_out,
  output logic                        reg_rvalid_out,
  // Time-sync clock
  input  wire logic [`TSC_TIME_W-1:0] clock_time_in,
  output tsc_clk_ctl_t                clock_ctl_out,
  // Trigger units
  input  wire logic [`TSC_WORD_W-1:0] trig_field_in,
  output logic [3:0]                  trig_rd_idx_out,
  output tsc_trig_ctl_t               trig_ctl_out
);

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  if (TRIG_UNITS < 1 || TRIG_UNITS > 8)
  begin : g_bad_units
    $error("TRIG_UNITS must lie between 1 and 8");
  end
  if (TRIG_FIELDS < 1 || TRIG_FIELDS > 15)
  begin : g_bad_fields
    $error("TRIG_FIELDS must lie between 1 and 15");
  end

  localparam logic [3:0] FIELDS_L = 4'(TRIG_FIELDS);
  localparam logic [3:0] CWORDS_L = 4'(`TSC_CLOCK_WORDS);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Picks one 16-bit word of a time value; words past the end read zero.
  function automatic logic [`TSC_WORD_W-1:0] word_of(input logic [`TSC_TIME_W-1:0] t,
                                                     input logic [3:0]              i);
    logic [`TSC_WORD_W-1:0] w;
    w = '0;
    if (i < CWORDS_L)
    begin
      w = t[i[1:0]*`TSC_WORD_W +: `TSC_WORD_W];
    end
    return w;
  endfunction

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  logic                   page_hit;
  logic                   ctl_wr;
  logic                   ctl_rd;
  logic                   tdr_wr;
  logic                   tdr_rd;
  logic [`TSC_WORD_W-1:0] wd;
  logic                   hold;
  logic                   cmd_ok;

  assign page_hit = (page_sel_in == `TSC_PAGE_TIME_SYNC);
  assign ctl_wr   = reg_req_in.wr && page_hit && (reg_req_in.addr == `TSC_ADDR_CONTROL);
  assign ctl_rd   = reg_req_in.rd && page_hit && (reg_req_in.addr == `TSC_ADDR_CONTROL);
  assign tdr_wr   = reg_req_in.wr && page_hit && (reg_req_in.addr == `TSC_ADDR_TIME_DATA);
  assign tdr_rd   = reg_req_in.rd && page_hit && (reg_req_in.addr == `TSC_ADDR_TIME_DATA);
  assign wd       = reg_req_in.wdata;

  // --------------------------------------------------------------------------
  // Logic reset bit
  // --------------------------------------------------------------------------
  logic logic_rst_r;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      logic_rst_r <= 1'(`TSC_CONTROL_RESET >> `TSC_BIT_LOGIC_RST);
    end
    else if (ctl_wr)
    begin
      logic_rst_r <= wd[`TSC_BIT_LOGIC_RST];
    end
  end

  // The value being written takes effect in the same cycle as the write.
  assign hold   = ctl_wr ? wd[`TSC_BIT_LOGIC_RST] : logic_rst_r;
  assign cmd_ok = ctl_wr && !hold;

  // --------------------------------------------------------------------------
  // Clock run state and select field
  // --------------------------------------------------------------------------
  logic       run_r;
  logic [2:0] sel_r;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      run_r <= 1'b0;
    end
    else if (hold)
    begin
      run_r <= 1'b0;
    end
    else if (cmd_ok && wd[`TSC_BIT_RUN_OFF])
    begin
      run_r <= 1'b0;
    end
    else if (cmd_ok && wd[`TSC_BIT_RUN_ON])
    begin
      run_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sel_r <= 3'h0;
    end
    else if (hold)
    begin
      sel_r <= 3'h0;
    end
    else if (cmd_ok)
    begin
      sel_r <= wd[`TSC_SEL_MSB:`TSC_SEL_LSB];
    end
  end

  // --------------------------------------------------------------------------
  // Time data port mode and word indices
  // --------------------------------------------------------------------------
  tsc_tdr_mode_t mode_r;
  logic [3:0]    wr_idx_r;
  logic [3:0]    rd_idx_r;
  logic          trigger_program_cmd;
  logic          trigger_readback_cmd;
  logic          trig_on;
  logic          load_last;

  assign trigger_program_cmd = cmd_ok && wd[`TSC_BIT_TRIGGER_PROGRAM_CMD];
  assign trigger_readback_cmd = cmd_ok && wd[`TSC_BIT_TRIGGER_READBACK_CMD];
  assign trig_on   = cmd_ok && wd[`TSC_BIT_TRIG_ON];
  assign load_last = tdr_wr && (mode_r == TSC_TDR_TRIG_LD) && (wr_idx_r == FIELDS_L - 4'h1);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_r <= TSC_TDR_CLOCK;
    end
    else if (hold)
    begin
      mode_r <= TSC_TDR_CLOCK;
    end
    else if (trig_on)
    begin
      mode_r <= TSC_TDR_CLOCK;
    end
    else if (trigger_program_cmd)
    begin
      mode_r <= TSC_TDR_TRIG_LD;
    end
    else if (trigger_readback_cmd)
    begin
      mode_r <= TSC_TDR_TRIG_RD;
    end
    else if (cmd_ok && wd[`TSC_BIT_CLK_SAMPLE])
    begin
      mode_r <= TSC_TDR_CLOCK;
    end
    else if (load_last)
    begin
      mode_r <= TSC_TDR_CLOCK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_idx_r <= 4'h0;
    end
    else if (hold || trigger_program_cmd || (cmd_ok && (wd[`TSC_BIT_CLK_SET] || wd[`TSC_BIT_CLK_ADJUST])))
    begin
      wr_idx_r <= 4'h0;
    end
    else if (tdr_wr && wr_idx_r != 4'hF)
    begin
      wr_idx_r <= wr_idx_r + 4'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_idx_r <= 4'h0;
    end
    else if (hold || trigger_readback_cmd || (cmd_ok && wd[`TSC_BIT_CLK_SAMPLE]))
    begin
      rd_idx_r <= 4'h0;
    end
    else if (tdr_rd && rd_idx_r != 4'hF)
    begin
      rd_idx_r <= rd_idx_r + 4'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Clock time staging and sample
  // --------------------------------------------------------------------------
  logic [`TSC_TIME_W-1:0] stage_r;
  logic [`TSC_TIME_W-1:0] snap_r;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      stage_r <= '0;
    end
    else if (hold)
    begin
      stage_r <= '0;
    end
    else if (tdr_wr && mode_r == TSC_TDR_CLOCK && wr_idx_r < CWORDS_L)
    begin
      stage_r[wr_idx_r[1:0]*`TSC_WORD_W +: `TSC_WORD_W] <= wd;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      snap_r <= '0;
    end
    else if (hold)
    begin
      snap_r <= '0;
    end
    else if (cmd_ok && wd[`TSC_BIT_CLK_SAMPLE])
    begin
      snap_r <= clock_time_in;
    end
  end

  // --------------------------------------------------------------------------
  // Clock command pulses
  // --------------------------------------------------------------------------
  logic sample_r;
  logic set_r;
  logic adjust_r;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sample_r <= 1'b0;
      set_r    <= 1'b0;
      adjust_r <= 1'b0;
    end
    else
    begin
      sample_r <= cmd_ok && wd[`TSC_BIT_CLK_SAMPLE];
      set_r    <= cmd_ok && wd[`TSC_BIT_CLK_SET];
      adjust_r <= cmd_ok && wd[`TSC_BIT_CLK_ADJUST];
    end
  end

  assign clock_ctl_out = '{logic_reset: logic_rst_r, run: run_r, sample: sample_r,
                           set: set_r, adjust: adjust_r, time_data: stage_r};

  // --------------------------------------------------------------------------
  // Trigger command pulses
  // --------------------------------------------------------------------------
  logic                   trigger_enable_cmd_r;
  logic                   trigger_disable_cmd_r;
  logic                   fld_wr_r;
  logic [3:0]             fld_idx_r;
  logic [`TSC_WORD_W-1:0] fld_data_r;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trigger_enable_cmd_r  <= 1'b0;
      trigger_disable_cmd_r <= 1'b0;
    end
    else
    begin
      trigger_enable_cmd_r  <= trig_on;
      // The disable pulse also fires on a trigger program command, not only on the disable bit.
      trigger_disable_cmd_r <= cmd_ok && (wd[`TSC_BIT_TRIG_OFF] || wd[`TSC_BIT_TRIGGER_PROGRAM_CMD]);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fld_wr_r   <= 1'b0;
      fld_idx_r  <= 4'h0;
      fld_data_r <= '0;
    end
    else
    begin
      fld_wr_r <= tdr_wr && !hold && mode_r == TSC_TDR_TRIG_LD && wr_idx_r < FIELDS_L;
      if (tdr_wr)
      begin
        fld_idx_r  <= wr_idx_r;
        fld_data_r <= wd;
      end
    end
  end

  assign trig_ctl_out    = '{sel: sel_r, enable: trigger_enable_cmd_r, disable_unit: trigger_disable_cmd_r,
                             field_wr: fld_wr_r, field_idx: fld_idx_r, field_data: fld_data_r};
  assign trig_rd_idx_out = rd_idx_r;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  logic [`TSC_WORD_W-1:0] ctl_view;
  logic [`TSC_WORD_W-1:0] rdata_r;
  logic                   rvalid_r;

  always_comb
  begin
    ctl_view                            = '0;
    ctl_view[`TSC_SEL_MSB:`TSC_SEL_LSB] = sel_r;
    ctl_view[`TSC_BIT_TRIGGER_PROGRAM_CMD]        = (mode_r == TSC_TDR_TRIG_LD);
    ctl_view[`TSC_BIT_RUN_ON]           = run_r;
    ctl_view[`TSC_BIT_LOGIC_RST]        = logic_rst_r;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= ctl_rd || tdr_rd;
      if (ctl_rd)
      begin
        rdata_r <= ctl_view;
      end
      else if (tdr_rd && mode_r == TSC_TDR_TRIG_RD)
      begin
        rdata_r <= (rd_idx_r < FIELDS_L) ? trig_field_in : '0;
      end
      else if (tdr_rd)
      begin
        rdata_r <= word_of(snap_r, rd_idx_r);
      end
    end
  end

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;

endmodule

// ---- test/tsc_far_model.sv ----
// Behavioural model of the time-sync clock and trigger units beside the control block.
// Assumes it shares clock and reset with the control block and follows its commands.
`timescale 1ns/1ps
`include "tsc_cfg.svh"

module tsc_far_model
  import tsc_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // Commands from the control block
  input  wire tsc_clk_ctl_t           clock_ctl_in,
  input  wire tsc_trig_ctl_t          trig_ctl_in,
  input  wire logic [3:0]             trig_rd_idx_in,
  // Clock time and trigger fields
  output logic [`TSC_TIME_W-1:0]      clock_time_out,
  output logic [`TSC_WORD_W-1:0]      trig_field_out
);
  logic [`TSC_WORD_W-1:0] field_r [8][16];

  // --------------------------------------------------------------------------
  // Clock time
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      clock_time_out <= '0;
    else if (clock_ctl_in.logic_reset)
      clock_time_out <= '0;
    else if (clock_ctl_in.set)
      clock_time_out <= clock_ctl_in.time_data;
    else if (clock_ctl_in.adjust)
      clock_time_out <= clock_time_out + clock_ctl_in.time_data;
    else if (clock_ctl_in.run)
      clock_time_out <= clock_time_out + 64'h8;

  // --------------------------------------------------------------------------
  // Trigger control fields
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      field_r <= '{default: '0};
    else if (trig_ctl_in.field_wr)
      field_r[trig_ctl_in.sel][trig_ctl_in.field_idx] <= trig_ctl_in.field_data;

  assign trig_field_out = field_r[trig_ctl_in.sel][trig_rd_idx_in];
endmodule

// ---- test/tsc_time_sync_control_properties.sv ----
// Concurrent checks on the ports of the time-sync control register.
// Assumes the package and header are compiled first; bound into the design.
`timescale 1ns/1ps
`include "tsc_cfg.svh"

module tsc_time_sync_control_properties
  import tsc_pkg::*;
#(
  parameter int TRIG_UNITS  = 8,
  parameter int TRIG_FIELDS = 6
)
(
  // Clock and reset
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  // Management register access
  input wire tsc_reg_req_t           reg_req_in,
  input wire logic [2:0]             page_sel_in,
  input wire logic [`TSC_WORD_W-1:0] reg_rdata_out,
  input wire logic                   reg_rvalid_out,
  // Time-sync clock
  input wire logic [`TSC_TIME_W-1:0] clock_time_in,
  input wire tsc_clk_ctl_t           clock_ctl_out,
  // Trigger units
  input wire logic [`TSC_WORD_W-1:0] trig_field_in,
  input wire logic [3:0]             trig_rd_idx_out,
  input wire tsc_trig_ctl_t          trig_ctl_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  logic pg4;
  logic wa;
  logic cw;
  logic cr;
  assign pg4 = page_sel_in == `TSC_PAGE_TIME_SYNC;
  assign wa  = pg4 && reg_req_in.wr && reg_req_in.addr == `TSC_ADDR_CONTROL;
  assign cw  = wa && !reg_req_in.wdata[0];
  assign cr  = pg4 && reg_req_in.rd && reg_req_in.addr == `TSC_ADDR_CONTROL;

  property p_off_page;
    !pg4 |=> !reg_rvalid_out;
  endproperty
  a_off_page: assert property (p_off_page)
    else $error("read answered off page four");

  property p_read_hit;
    pg4 && reg_req_in.rd && reg_req_in.addr[4:1] == 4'hA |=> reg_rvalid_out;
  endproperty
  a_read_hit: assert property (p_read_hit)
    else $error("read on page four not answered");

  property p_reserved;
    cr |=> reg_rdata_out[15:13] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits read nonzero");

  property p_self_clear;
    cr |=> reg_rdata_out[9:7] == 3'h0 && reg_rdata_out[5:3] == 3'h0 && !reg_rdata_out[1];
  endproperty
  a_self_clear: assert property (p_self_clear)
    else $error("command bit read back nonzero");

  property p_select;
    cw |=> trig_ctl_out.sel == $past(reg_req_in.wdata[12:10]);
  endproperty
  a_select: assert property (p_select)
    else $error("trigger select not taken");

  property p_trig_cmds;
    cw && reg_req_in.wdata[9:8] != 2'h0 |=>
      trig_ctl_out.enable == $past(reg_req_in.wdata[8]) &&
      (trig_ctl_out.disable_unit || !$past(reg_req_in.wdata[9]));
  endproperty
  a_trig_cmds: assert property (p_trig_cmds)
    else $error("trigger command pulse wrong");

  property p_load_off;
    cw && reg_req_in.wdata[6] |=> trig_ctl_out.disable_unit;
  endproperty
  a_load_off: assert property (p_load_off)
    else $error("trigger load did not disable unit");

  property p_clk_cmds;
    cw |=> {clock_ctl_out.sample, clock_ctl_out.set, clock_ctl_out.adjust} ==
           $past(reg_req_in.wdata[5:3]);
  endproperty
  a_clk_cmds: assert property (p_clk_cmds)
    else $error("clock command pulse wrong");

  property p_run_on;
    cw && reg_req_in.wdata[2:1] == 2'h2 |=> clock_ctl_out.run;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("clock did not start");

  property p_run_off;
    cw && reg_req_in.wdata[1] |=> !clock_ctl_out.run;
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("clock did not stop");

  property p_run_stays;
    !clock_ctl_out.run && !(cw && reg_req_in.wdata[2]) |=> !clock_ctl_out.run;
  endproperty
  a_run_stays: assert property (p_run_stays)
    else $error("clock started without a start command");

  property p_rst_set;
    wa && reg_req_in.wdata[0] |=> clock_ctl_out.logic_reset && !clock_ctl_out.run
                                  && trig_ctl_out.sel == 3'h0;
  endproperty
  a_rst_set: assert property (p_rst_set)
    else $error("logic reset did not clear state");

  property p_rst_hold;
    clock_ctl_out.logic_reset && !cw |=> clock_ctl_out.logic_reset;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("logic reset released by itself");
endmodule

bind tsc_time_sync_control tsc_time_sync_control_properties #(
  .TRIG_UNITS(TRIG_UNITS), .TRIG_FIELDS(TRIG_FIELDS)) tsc_time_sync_control_properties_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(reg_req_in),
  .page_sel_in(page_sel_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .clock_time_in(clock_time_in),
  .clock_ctl_out(clock_ctl_out), .trig_field_in(trig_field_in),
  .trig_rd_idx_out(trig_rd_idx_out), .trig_ctl_out(trig_ctl_out));

// ---- test/testbench.sv ----
// Self-checking bench for the time-sync control register.
// Assumes the design, its package and the far-side model are compiled first.
`timescale 1ns/1ps
`include "tsc_cfg.svh"

module testbench
  import tsc_pkg::*;
;
  localparam int         NF  = 6;
  localparam logic [4:0] CTL = `TSC_ADDR_CONTROL;
  localparam logic [4:0] TDR = `TSC_ADDR_TIME_DATA;

  logic          clk_in = 1'b0;
  logic          rst_n_in = 1'b0;
  tsc_reg_req_t  req = '0;
  logic [2:0]    page = 3'h4;
  logic [2:0]    pg = 3'h4;
  logic [15:0]   rdata, field, w;
  logic          rvalid, run_exp;
  logic [63:0]   ctime, t, d;
  logic [3:0]    idx;
  tsc_clk_ctl_t  cctl;
  tsc_trig_ctl_t tctl;
  logic [15:0]   fl [NF];
  int            errors = 0;
  int            comparisons = 0;
  int            cycles = 0;
  int            seed = 90;

  always #50 clk_in = ~clk_in;

  tsc_time_sync_control #(.TRIG_UNITS(8), .TRIG_FIELDS(NF)) tsc_time_sync_control_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_req_in(req), .page_sel_in(page),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .clock_time_in(ctime),
    .clock_ctl_out(cctl), .trig_field_in(field), .trig_rd_idx_out(idx),
    .trig_ctl_out(tctl));

  tsc_far_model tsc_far_model_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clock_ctl_in(cctl), .trig_ctl_in(tctl),
    .trig_rd_idx_in(idx), .clock_time_out(ctime), .trig_field_out(field));

  function automatic logic [15:0] ctl_exp(input logic [15:0] v, input logic run);
    return {3'h0, v[12:10], 7'h00, run, 2'h0};
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_in);
    page <= pg;
    req  <= '{wr: wr, rd: !wr, addr: a, wdata: v};
    @(posedge clk_in);
    req  <= '0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    check({15'h0, rvalid}, 16'h0001);
    check(rdata, exp);
  endtask

  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(CTL, 16'h0000);
    pg = 3'h3;
    acc(1'b1, CTL, 16'h0004);
    acc(1'b0, CTL, 16'h0000);
    check({15'h0, rvalid}, 16'h0000);
    pg = 3'h4;
    rd(CTL, 16'h0000);
    run_exp = 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      w = (i == 0) ? 16'hFFBE : 16'($random(seed)) & 16'hFFBE;
      acc(1'b1, CTL, w);
      if (w[1])
        run_exp = 1'b0;
      else if (w[2])
        run_exp = 1'b1;
      rd(CTL, ctl_exp(w, run_exp));
    end
    acc(1'b1, CTL, 16'h0001);
    rd(CTL, 16'h0001);
    acc(1'b1, CTL, 16'h0025);
    rd(CTL, 16'h0001);
    acc(1'b1, CTL, 16'h0000);
    rd(CTL, 16'h0000);
    t = {$random(seed), $random(seed)};
    d = {$random(seed), $random(seed)};
    for (int i = 0; i < 5; i++)
      acc(1'b1, TDR, 16'(t >> (16 * i)));
    acc(1'b1, CTL, 16'h0010);
    acc(1'b1, CTL, 16'h0020);
    for (int i = 0; i < 5; i++)
      rd(TDR, 16'(t >> (16 * i)));
    for (int i = 0; i < 4; i++)
      acc(1'b1, TDR, 16'(d >> (16 * i)));
    acc(1'b1, CTL, 16'h0008);
    acc(1'b1, CTL, 16'h0020);
    for (int i = 0; i < 4; i++)
      rd(TDR, 16'((t + d) >> (16 * i)));
    acc(1'b1, CTL, 16'h0C40);
    rd(CTL, 16'h0C40);
    for (int i = 0; i < NF; i++)
    begin
      fl[i] = 16'($random(seed));
      acc(1'b1, TDR, fl[i]);
    end
    rd(CTL, 16'h0C00);
    acc(1'b1, CTL, 16'h0C80);
    for (int i = 0; i <= NF; i++)
      rd(TDR, (i < NF) ? fl[i] : 16'h0000);
    acc(1'b1, CTL, 16'h0840);
    acc(1'b1, TDR, 16'hA5A5);
    acc(1'b1, CTL, 16'h0900);
    rd(CTL, 16'h0800);
    close_out();
  end
endmodule
